// *** logic/perf_event_pkg.sv ***
// Package for the instruction and trap event qualification block
// Operation
// - Cycle event counts every enabled clock, split by user/system trace bits
// - Total instruction event counts all commits including both prefix types
// - Effective instruction event counts commits without any prefix instructions
// - Load/store event counts scalar loads, stores, atomics; SIMD forms separate
// - Branch event counts committed branches, calls, jump-and-link and returns
// - Two-operand FP counts both opcode groups plus group-1 opf 16/17 hex
// - Three-operand FP counts scalar fused multiply-add/subtract and trig multiply-add
// - SIMD two- and three-operand FP events count SIMD forms of same classes
// - Prefix events per type, plus events for unpacked prefixes per type
// - All-traps event equals the sum of the individual trap events
// - Each trap category has its own separate event
// - Flow event counts each internal flow, never packed prefixes
// - Integer load and store events; stores include swap, ldstub, compare-swap
// - Scalar FP load/store events exclude SIMD and quad; SIMD events separate
// - Issue-buffer-empty event counts cycles with empty four-entry issue word
// - Execution-halt event counts halts for trap, privileged update, ordering, retry
// - Flush event counts once per mispredict pipeline flush
// - Five issue-width events count cycles issuing zero to three, or four or more, instructions
// - Decode interlock includes sync and window interlocks, no dynamic stalls
// - Memory wait: zero commit, oldest is non-store access; four sub-events
// - Execution wait takes priority over branch wait
// - Zero-commit counts cycles with no commit or only prefix commits
package perf_event_pkg;
    localparam int CNT_WIDTH    = 32;
    localparam int NUM_COUNTERS = 4;
    localparam int COMMIT_WIDTH = 4;
    localparam int INC_WIDTH    = 5;
    localparam logic [4:0] OPF_HI_A = 5'h16;
    localparam logic [4:0] OPF_HI_B = 5'h17;
    localparam logic [CNT_WIDTH-1:0] CNT_RESET = 32'h0;

    typedef logic [INC_WIDTH-1:0] inc_t;

    typedef enum logic [5:0] {
        EV_CYCLE, EV_INSN_TOTAL, EV_INSN_EFF, EV_LDST, EV_BRANCH,
        EV_FP2, EV_FP3, EV_SIMD_LDST, EV_SIMD_FP2, EV_SIMD_FP3,
        EV_PREFIX_ONE, EV_PREFIX_TWO, EV_UNPACK_ONE, EV_UNPACK_TWO,
        EV_TRAP_ALL, EV_TRAP_INT_VEC, EV_TRAP_INT_LVL, EV_TRAP_SPILL,
        EV_TRAP_FILL, EV_TRAP_INSN, EV_TRAP_IMMU, EV_TRAP_DMMU,
        EV_TRAP_SIMD_PAGE, EV_FLOW, EV_INT_LOAD, EV_INT_STORE,
        EV_FL_LOAD, EV_FL_STORE, EV_SIMD_FL_LOAD, EV_SIMD_FL_STORE,
        EV_ISSUE_EMPTY, EV_EXEC_HALT, EV_FLUSH, EV_ISSUE0, EV_ISSUE1,
        EV_ISSUE2, EV_ISSUE3, EV_ISSUE4, EV_SYNC_INTLK, EV_REGWIN_INTLK,
        EV_DECODE_INTLK, EV_MEM_WAIT, EV_MEM_WAIT_NC, EV_MEM_WAIT_INT,
        EV_MEM_WAIT_L2MISS, EV_MEM_WAIT_PFP, EV_EXEC_WAIT,
        EV_BRANCH_WAIT, EV_ZERO_COMMIT, EV_COUNT
    } event_sel_t;

    localparam int NUM_EVENTS = int'(EV_COUNT);

    typedef inc_t [NUM_EVENTS-1:0] inc_vec_t;

    typedef struct packed {
        logic       valid;
        logic       simd;
        logic       int_load;
        logic       int_store;
        logic       fl_load;
        logic       fl_store;
        logic       quad;
        logic       branch;
        logic       fpop;
        logic       impdep1;
        logic [4:0] opf_hi;
        logic       fma;
        logic [1:0] flows;
    } commit_slot_t;

    typedef struct packed {
        commit_slot_t [COMMIT_WIDTH-1:0] slot;
        logic [1:0] prefix_one_packed;
        logic [1:0] prefix_one_unpacked;
        logic [1:0] prefix_two_packed;
        logic [1:0] prefix_two_unpacked;
    } commit_grp_t;

    typedef struct packed {
        logic int_vector;
        logic int_level;
        logic spill;
        logic fill;
        logic trap_insn;
        logic immu_miss;
        logic dmmu_miss;
        logic simd_page;
    } trap_vec_t;

    typedef struct packed {
        logic is_mem;
        logic is_store;
        logic noncache;
        logic integer_op;
        logic l2_miss;
        logic pfp_busy;
        logic is_eu;
        logic is_branch;
    } oldest_t;

    typedef struct packed {
        logic [2:0] count;
        logic       iwr_empty;
        logic       sync_intlk;
        logic       regwin_intlk;
        logic       other_static_intlk;
        logic       halt_trap;
        logic       halt_priv;
        logic       halt_order;
        logic       halt_retry;
        logic       mispredict_flush_event;
    } issue_t;

    typedef struct packed {
        logic       enable;
        logic       user_trace_enable;
        logic       system_trace_enable;
        event_sel_t sel;
    } ctrl_t;
endpackage : perf_event_pkg

// *** logic/perf_counter_unit.sv ***
// One selectable performance counter
`timescale 1ns/1ps
`default_nettype none
module perf_counter_unit (
    input  wire logic                                i_clk,
    input  wire logic                                i_reset,
    input  wire perf_event_pkg::ctrl_t               i_ctrl,
    input  wire logic                                i_system_mode,
    input  wire logic                                i_clear,
    input  wire perf_event_pkg::inc_vec_t            i_incs,
    output logic [perf_event_pkg::CNT_WIDTH-1:0]     o_count
);
    logic [perf_event_pkg::CNT_WIDTH-1:0] count_reg;
    logic [perf_event_pkg::CNT_WIDTH-1:0] count_next;
    logic                                 priv_ok;
    logic                                 sel_ok;

    always_comb begin
        priv_ok = i_system_mode ? i_ctrl.system_trace_enable
                                : i_ctrl.user_trace_enable;
    end

    // Unused encodings count nothing rather than index past the table
    always_comb begin
        sel_ok     = i_ctrl.sel < perf_event_pkg::EV_COUNT;
        count_next = count_reg;
        if (i_ctrl.enable && priv_ok && sel_ok) begin
            count_next = count_reg
                + perf_event_pkg::CNT_WIDTH'(i_incs[i_ctrl.sel]);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || i_clear) begin
            count_reg <= perf_event_pkg::CNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    assign o_count = count_reg;
endmodule : perf_counter_unit
`default_nettype wire

// *** logic/perf_event_instr_trap_stats.sv ***
// Event qualification and counters for instruction and trap statistics
`timescale 1ns/1ps
`default_nettype none
module perf_event_instr_trap_stats (
    input  wire logic                                   i_clk,
    input  wire logic                                   i_reset,
    input  wire logic                                   i_system_mode,
    input  wire perf_event_pkg::commit_grp_t            i_commit,
    input  wire perf_event_pkg::trap_vec_t              i_trap,
    input  wire perf_event_pkg::oldest_t                i_oldest,
    input  wire perf_event_pkg::issue_t                 i_issue,
    input  wire perf_event_pkg::ctrl_t
                [perf_event_pkg::NUM_COUNTERS-1:0]      i_ctrl,
    input  wire logic
                [perf_event_pkg::NUM_COUNTERS-1:0]      i_clear,
    output logic [perf_event_pkg::NUM_COUNTERS-1:0]
                 [perf_event_pkg::CNT_WIDTH-1:0]        o_counts
);
    localparam int CW = perf_event_pkg::COMMIT_WIDTH;

    perf_event_pkg::inc_vec_t inc;

    logic [CW-1:0] m_valid;
    logic [CW-1:0] m_ldst;
    logic [CW-1:0] m_simd_ldst;
    logic [CW-1:0] m_branch;
    logic [CW-1:0] m_fp2;
    logic [CW-1:0] m_fp3;
    logic [CW-1:0] m_simd_fp2;
    logic [CW-1:0] m_simd_fp3;
    logic [CW-1:0] m_int_load;
    logic [CW-1:0] m_int_store;
    logic [CW-1:0] m_fl_load;
    logic [CW-1:0] m_fl_store;
    logic [CW-1:0] m_simd_fl_load;
    logic [CW-1:0] m_simd_fl_store;
    perf_event_pkg::inc_t flow_sum;
    perf_event_pkg::inc_t normal_cnt;
    perf_event_pkg::inc_t prefix_one;
    perf_event_pkg::inc_t prefix_two;
    perf_event_pkg::inc_t unpack_one;
    perf_event_pkg::inc_t unpack_two;
    perf_event_pkg::inc_t trap_sum;
    logic zero_commit;
    logic mem_wait;
    logic fp2_class;

    function automatic perf_event_pkg::inc_t count_bits(
        input logic [CW-1:0] m
    );
        perf_event_pkg::inc_t s;
        s = '0;
        for (int i = 0; i < CW; i++) begin
            s = s + perf_event_pkg::inc_t'(m[i]);
        end
        return s;
    endfunction : count_bits

    // Only the commit group feeds these masks, so cancelled work never counts
    always_comb begin
        flow_sum = '0;
        for (int i = 0; i < CW; i++) begin
            perf_event_pkg::commit_slot_t s;
            s = i_commit.slot[i];
            fp2_class = s.fpop || (s.impdep1 &&
                ((s.opf_hi == perf_event_pkg::OPF_HI_A) ||
                 (s.opf_hi == perf_event_pkg::OPF_HI_B)));
            m_valid[i]  = s.valid;
            m_ldst[i]   = s.valid && !s.simd &&
                (s.int_load || s.int_store ||
                 s.fl_load || s.fl_store);
            m_simd_ldst[i] = s.valid && s.simd &&
                (s.fl_load || s.fl_store);
            m_branch[i] = s.valid && s.branch;
            m_fp2[i]      = s.valid && !s.simd && fp2_class;
            m_fp3[i]      = s.valid && !s.simd && s.fma;
            m_simd_fp2[i] = s.valid && s.simd && fp2_class;
            m_simd_fp3[i] = s.valid && s.simd && s.fma;
            m_int_load[i]  = s.valid && s.int_load;
            m_int_store[i] = s.valid && s.int_store;
            m_fl_load[i]  = s.valid && !s.simd && !s.quad &&
                s.fl_load;
            m_fl_store[i] = s.valid && !s.simd && !s.quad &&
                s.fl_store;
            m_simd_fl_load[i]  = s.valid && s.simd && s.fl_load;
            m_simd_fl_store[i] = s.valid && s.simd && s.fl_store;
            if (s.valid) begin
                flow_sum = flow_sum
                    + perf_event_pkg::inc_t'(s.flows);
            end
        end
    end

    always_comb begin
        normal_cnt = count_bits(m_valid);
        prefix_one = perf_event_pkg::inc_t'(i_commit.prefix_one_packed)
            + perf_event_pkg::inc_t'(i_commit.prefix_one_unpacked);
        prefix_two = perf_event_pkg::inc_t'(i_commit.prefix_two_packed)
            + perf_event_pkg::inc_t'(i_commit.prefix_two_unpacked);
        unpack_one =
            perf_event_pkg::inc_t'(i_commit.prefix_one_unpacked);
        unpack_two =
            perf_event_pkg::inc_t'(i_commit.prefix_two_unpacked);
        trap_sum = count_bits(i_trap[3:0])
            + count_bits(i_trap[7:4]);
        // Prefix-only cycles still count as zero commit
        zero_commit = (normal_cnt == '0);
        mem_wait = zero_commit && i_oldest.is_mem &&
            !i_oldest.is_store;
    end

    always_comb begin
        inc = '0;
        inc[perf_event_pkg::EV_CYCLE]      = 5'h01;
        inc[perf_event_pkg::EV_INSN_TOTAL] =
            normal_cnt + prefix_one + prefix_two;
        inc[perf_event_pkg::EV_INSN_EFF]   = normal_cnt;
        inc[perf_event_pkg::EV_LDST]       = count_bits(m_ldst);
        inc[perf_event_pkg::EV_SIMD_LDST]  = count_bits(m_simd_ldst);
        inc[perf_event_pkg::EV_BRANCH]     = count_bits(m_branch);
        inc[perf_event_pkg::EV_FP2]        = count_bits(m_fp2);
        inc[perf_event_pkg::EV_FP3]        = count_bits(m_fp3);
        inc[perf_event_pkg::EV_SIMD_FP2]   = count_bits(m_simd_fp2);
        inc[perf_event_pkg::EV_SIMD_FP3]   = count_bits(m_simd_fp3);
        inc[perf_event_pkg::EV_PREFIX_ONE] = prefix_one;
        inc[perf_event_pkg::EV_PREFIX_TWO] = prefix_two;
        inc[perf_event_pkg::EV_UNPACK_ONE] = unpack_one;
        inc[perf_event_pkg::EV_UNPACK_TWO] = unpack_two;
        inc[perf_event_pkg::EV_TRAP_ALL]   = trap_sum;
        inc[perf_event_pkg::EV_TRAP_INT_VEC] =
            perf_event_pkg::inc_t'(i_trap.int_vector);
        inc[perf_event_pkg::EV_TRAP_INT_LVL] =
            perf_event_pkg::inc_t'(i_trap.int_level);
        inc[perf_event_pkg::EV_TRAP_SPILL] =
            perf_event_pkg::inc_t'(i_trap.spill);
        inc[perf_event_pkg::EV_TRAP_FILL] =
            perf_event_pkg::inc_t'(i_trap.fill);
        inc[perf_event_pkg::EV_TRAP_INSN] =
            perf_event_pkg::inc_t'(i_trap.trap_insn);
        inc[perf_event_pkg::EV_TRAP_IMMU] =
            perf_event_pkg::inc_t'(i_trap.immu_miss);
        inc[perf_event_pkg::EV_TRAP_DMMU] =
            perf_event_pkg::inc_t'(i_trap.dmmu_miss);
        inc[perf_event_pkg::EV_TRAP_SIMD_PAGE] =
            perf_event_pkg::inc_t'(i_trap.simd_page);
        // Unpacked prefixes run as flows, packed ones ride along free
        inc[perf_event_pkg::EV_FLOW] = flow_sum + unpack_one
            + unpack_two;
        inc[perf_event_pkg::EV_INT_LOAD]  = count_bits(m_int_load);
        inc[perf_event_pkg::EV_INT_STORE] = count_bits(m_int_store);
        inc[perf_event_pkg::EV_FL_LOAD]   = count_bits(m_fl_load);
        inc[perf_event_pkg::EV_FL_STORE]  = count_bits(m_fl_store);
        inc[perf_event_pkg::EV_SIMD_FL_LOAD]  = count_bits(m_simd_fl_load);
        inc[perf_event_pkg::EV_SIMD_FL_STORE] = count_bits(m_simd_fl_store);
        inc[perf_event_pkg::EV_ISSUE_EMPTY] =
            perf_event_pkg::inc_t'(i_issue.iwr_empty);
        inc[perf_event_pkg::EV_EXEC_HALT] = perf_event_pkg::inc_t'(
            i_issue.halt_trap || i_issue.halt_priv ||
            i_issue.halt_order || i_issue.halt_retry);
        inc[perf_event_pkg::EV_FLUSH] = perf_event_pkg::inc_t'(
            i_issue.mispredict_flush_event);
        // Upstream counts flows and prefixes into the issue count
        inc[perf_event_pkg::EV_ISSUE0] =
            perf_event_pkg::inc_t'(i_issue.count == 3'h0);
        inc[perf_event_pkg::EV_ISSUE1] =
            perf_event_pkg::inc_t'(i_issue.count == 3'h1);
        inc[perf_event_pkg::EV_ISSUE2] =
            perf_event_pkg::inc_t'(i_issue.count == 3'h2);
        inc[perf_event_pkg::EV_ISSUE3] =
            perf_event_pkg::inc_t'(i_issue.count == 3'h3);
        inc[perf_event_pkg::EV_ISSUE4] =
            perf_event_pkg::inc_t'(i_issue.count >= 3'h4);
        inc[perf_event_pkg::EV_SYNC_INTLK] =
            perf_event_pkg::inc_t'(i_issue.sync_intlk);
        inc[perf_event_pkg::EV_REGWIN_INTLK] =
            perf_event_pkg::inc_t'(i_issue.regwin_intlk);
        // Dynamic stalls have no input here, so they cannot leak in
        inc[perf_event_pkg::EV_DECODE_INTLK] = perf_event_pkg::inc_t'(
            i_issue.sync_intlk || i_issue.regwin_intlk ||
            i_issue.other_static_intlk);
        inc[perf_event_pkg::EV_MEM_WAIT] =
            perf_event_pkg::inc_t'(mem_wait);
        inc[perf_event_pkg::EV_MEM_WAIT_NC] =
            perf_event_pkg::inc_t'(mem_wait && i_oldest.noncache);
        inc[perf_event_pkg::EV_MEM_WAIT_INT] =
            perf_event_pkg::inc_t'(mem_wait && i_oldest.integer_op);
        inc[perf_event_pkg::EV_MEM_WAIT_L2MISS] =
            perf_event_pkg::inc_t'(mem_wait && i_oldest.l2_miss);
        inc[perf_event_pkg::EV_MEM_WAIT_PFP] =
            perf_event_pkg::inc_t'(mem_wait && i_oldest.pfp_busy);
        inc[perf_event_pkg::EV_EXEC_WAIT] =
            perf_event_pkg::inc_t'(zero_commit && i_oldest.is_eu);
        inc[perf_event_pkg::EV_BRANCH_WAIT] = perf_event_pkg::inc_t'(
            zero_commit && i_oldest.is_branch && !i_oldest.is_eu);
        inc[perf_event_pkg::EV_ZERO_COMMIT] =
            perf_event_pkg::inc_t'(zero_commit);
    end

    genvar g;
    generate
        for (g = 0; g < perf_event_pkg::NUM_COUNTERS; g++) begin : g_cnt
            perf_counter_unit u_cnt (
                .i_clk         (i_clk),
                .i_reset       (i_reset),
                .i_ctrl        (i_ctrl[g]),
                .i_system_mode (i_system_mode),
                .i_clear       (i_clear[g]),
                .i_incs        (inc),
                .o_count       (o_counts[g])
            );
        end
    endgenerate

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    logic c0_live;
    assign c0_live = i_ctrl[0].enable && !i_clear[0] &&
        (i_system_mode ? i_ctrl[0].system_trace_enable
                       : i_ctrl[0].user_trace_enable);

    cycle_count_a: assert property (
        c0_live && i_ctrl[0].sel == perf_event_pkg::EV_CYCLE
        |=> o_counts[0] == $past(o_counts[0]) + 32'h1)
        else $error("cycle counter did not step by one");

    gated_hold_a: assert property (
        !c0_live && !i_clear[0]
        |=> o_counts[0] == $past(o_counts[0]))
        else $error("gated counter changed");

    counter_add_a: assert property (
        c0_live && i_ctrl[0].sel < perf_event_pkg::EV_COUNT
        |=> o_counts[0] == $past(o_counts[0])
            + 32'($past(inc[i_ctrl[0].sel])))
        else $error("counter added wrong increment");

    // Checked against the raw prefix fields, not the internal sums
    total_split_a: assert property (
        inc[perf_event_pkg::EV_INSN_TOTAL] == inc[perf_event_pkg::EV_INSN_EFF]
        + 5'(i_commit.prefix_one_packed) + 5'(i_commit.prefix_one_unpacked)
        + 5'(i_commit.prefix_two_packed) + 5'(i_commit.prefix_two_unpacked))
        else $error("total instructions mismatch");

    trap_sum_a: assert property (
        inc[perf_event_pkg::EV_TRAP_ALL] ==
        inc[perf_event_pkg::EV_TRAP_INT_VEC] +
        inc[perf_event_pkg::EV_TRAP_INT_LVL] +
        inc[perf_event_pkg::EV_TRAP_SPILL] +
        inc[perf_event_pkg::EV_TRAP_FILL] +
        inc[perf_event_pkg::EV_TRAP_INSN] +
        inc[perf_event_pkg::EV_TRAP_IMMU] +
        inc[perf_event_pkg::EV_TRAP_DMMU] +
        inc[perf_event_pkg::EV_TRAP_SIMD_PAGE])
        else $error("trap total differs from categories");

    issue_onehot_a: assert property (
        inc[perf_event_pkg::EV_ISSUE0] + inc[perf_event_pkg::EV_ISSUE1] +
        inc[perf_event_pkg::EV_ISSUE2] + inc[perf_event_pkg::EV_ISSUE3] +
        inc[perf_event_pkg::EV_ISSUE4] == 5'h01)
        else $error("issue width events not exclusive");

    decode_cover_a: assert property (
        inc[perf_event_pkg::EV_SYNC_INTLK] != '0 ||
        inc[perf_event_pkg::EV_REGWIN_INTLK] != '0
        |-> inc[perf_event_pkg::EV_DECODE_INTLK] == 5'h01)
        else $error("decode interlock misses a sub-cause");

    mem_store_a: assert property (
        i_oldest.is_store || normal_cnt != '0
        |-> inc[perf_event_pkg::EV_MEM_WAIT] == '0)
        else $error("memory wait counted a store or commit");

    wait_priority_a: assert property (
        inc[perf_event_pkg::EV_EXEC_WAIT] != '0
        |-> inc[perf_event_pkg::EV_BRANCH_WAIT] == '0)
        else $error("branch wait beat execution wait");

    zero_commit_a: assert property (
        (i_commit.slot[0].valid || i_commit.slot[1].valid ||
         i_commit.slot[2].valid || i_commit.slot[3].valid)
        != inc[perf_event_pkg::EV_ZERO_COMMIT][0])
        else $error("zero commit wrong");

    ldst_simd_a: assert property (
        inc[perf_event_pkg::EV_LDST] + inc[perf_event_pkg::EV_SIMD_LDST]
        <= normal_cnt)
        else $error("load/store overcount");

    cyc_run_c: cover property (c0_live [*4]);
    trap_c: cover property (inc[perf_event_pkg::EV_TRAP_ALL] != '0);
    prefix_only_c: cover property (
        zero_commit && inc[perf_event_pkg::EV_INSN_TOTAL] != '0);
    wide_c: cover property (
        inc[perf_event_pkg::EV_INSN_TOTAL] > 5'h04);
endmodule : perf_event_instr_trap_stats
`default_nettype wire

// *** tb/perf_event_instr_trap_stats_tb.sv ***
// Self-checking bench for the instruction and trap event counters
`timescale 1ns/1ps
`default_nettype none
module perf_event_instr_trap_stats_tb;
    localparam int LIMIT = 3000;
    localparam logic [9:0] V = 10'h200, SM = 10'h100, IL = 10'h080, IS = 10'h040;
    localparam logic [9:0] FL = 10'h020, FS = 10'h010, QD = 10'h008, BR = 10'h004;
    localparam logic [9:0] FP = 10'h002, IMP = 10'h001;
    logic                        i_clk = 1'b0;
    logic                        i_reset = 1'b1;
    logic                        sys_mode = 1'b0;
    perf_event_pkg::commit_grp_t commit = '0;
    perf_event_pkg::trap_vec_t   trap = '0;
    perf_event_pkg::oldest_t     oldest = '0;
    perf_event_pkg::issue_t      issue = '0;
    perf_event_pkg::ctrl_t [3:0] ctrl = '0;
    logic [3:0]                  clr = 4'h0;
    logic [3:0][31:0]            counts;
    int                          n_fail = 0;
    int                          checked = 0;
    int                          cyc = 0;

    perf_event_instr_trap_stats i_dut (.i_clk(i_clk), .i_reset(i_reset),
        .i_system_mode(sys_mode), .i_commit(commit), .i_trap(trap), .i_oldest(oldest),
        .i_issue(issue), .i_ctrl(ctrl), .i_clear(clr), .o_counts(counts));

    always #5 i_clk = ~i_clk;

    // Cuts a hang short; all tests together need under a hundred cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            $display("[ERR] %0t timeout", $time);
            n_fail++;
            report_and_stop();
        end
    end

    function automatic perf_event_pkg::commit_slot_t sl(input logic [9:0] f,
            input logic [4:0] opf, input logic fma, input logic [1:0] fw);
        return {f, opf, fma, fw};
    endfunction : sl

    function automatic perf_event_pkg::event_sel_t tsel(input int k);
        return perf_event_pkg::event_sel_t'(int'(perf_event_pkg::EV_TRAP_INT_VEC) + k);
    endfunction : tsel

    task automatic idle();
        commit <= '0;
        trap   <= '0;
        oldest <= '0;
        issue  <= '0;
    endtask : idle

    // Clear wins over the idle-cycle increments, so counters start from zero
    task automatic prep(input perf_event_pkg::event_sel_t s0, s1, s2, s3);
        @(posedge i_clk);
        idle();
        sys_mode <= 1'b0;
        ctrl <= {{3'h7, s3}, {3'h7, s2}, {3'h7, s1}, {3'h7, s0}};
        clr <= 4'hf;
        @(posedge i_clk);
        clr <= 4'h0;
    endtask : prep

    // Freezes counters by disabling them, then compares all four
    task automatic fin(input string nm, input logic [31:0] e0, e1, e2, e3);
        logic [31:0] ex [4];
        @(posedge i_clk);
        idle();
        for (int g = 0; g < 4; g++) begin
            ctrl[g].enable <= 1'b0;
        end
        @(posedge i_clk);
        #1;
        ex = '{e0, e1, e2, e3};
        for (int g = 0; g < 4; g++) begin
            checked++;
            if (counts[g] !== ex[g]) begin
                n_fail++;
                $display("[ERR] %0t %s cnt%0d got %h exp %h", $time, nm, g, counts[g], ex[g]);
            end
        end
        $display("done %s", nm);
    endtask : fin

    task automatic t_commit();
        for (int k = 0; k < 2; k++) begin
            if (k == 0) begin
                prep(perf_event_pkg::EV_INSN_TOTAL, perf_event_pkg::EV_INSN_EFF,
                     perf_event_pkg::EV_FLOW, perf_event_pkg::EV_ZERO_COMMIT);
            end else begin
                prep(perf_event_pkg::EV_PREFIX_ONE, perf_event_pkg::EV_PREFIX_TWO,
                     perf_event_pkg::EV_UNPACK_ONE, perf_event_pkg::EV_UNPACK_TWO);
            end
            commit <= {sl(V, 5'h0, 1'b0, 2'h1), sl(V, 5'h0, 1'b0, 2'h3),
                       sl(V, 5'h0, 1'b0, 2'h2), sl(V, 5'h0, 1'b0, 2'h1), 8'hd6};
            @(posedge i_clk);
            commit <= {{4{sl(IL, 5'h0, 1'b0, 2'h3)}}, 8'h04};
            if (k == 0) begin
                fin("commit", 32'hc, 32'h4, 32'ha, 32'h1);
            end else begin
                fin("prefix", 32'h4, 32'h4, 32'h1, 32'h2);
            end
        end
    endtask : t_commit

    task automatic t_class();
        prep(perf_event_pkg::EV_LDST, perf_event_pkg::EV_BRANCH,
             perf_event_pkg::EV_FP2, perf_event_pkg::EV_FP3);
        commit <= {sl(V | IL, 5'h0, 1'b0, 2'h1), sl(V | SM | FS, 5'h0, 1'b0, 2'h1),
                   sl(V | BR, 5'h0, 1'b0, 2'h1), sl(V | IMP, 5'h16, 1'b0, 2'h1), 8'h0};
        @(posedge i_clk);
        commit <= {sl(V | SM | FP, 5'h0, 1'b0, 2'h1), sl(V, 5'h0, 1'b1, 2'h1),
                   sl(V | IMP, 5'h17, 1'b0, 2'h1), sl(V | IMP, 5'h15, 1'b0, 2'h1), 8'h0};
        fin("class", 32'h1, 32'h1, 32'h2, 32'h1);
    endtask : t_class

    task automatic t_simd();
        prep(perf_event_pkg::EV_SIMD_LDST, perf_event_pkg::EV_FL_LOAD,
             perf_event_pkg::EV_INT_STORE, perf_event_pkg::EV_SIMD_FP3);
        commit <= {sl(V | SM | FL, 5'h0, 1'b0, 2'h1), sl(V | FL | QD, 5'h0, 1'b0, 2'h1),
                   sl(V | FL, 5'h0, 1'b0, 2'h1), sl(V | IS, 5'h0, 1'b0, 2'h1), 8'h0};
        @(posedge i_clk);
        commit <= {sl(V | SM, 5'h0, 1'b1, 2'h1), sl(V, 5'h0, 1'b1, 2'h1), 36'h0, 8'h0};
        fin("simd", 32'h1, 32'h1, 32'h1, 32'h1);
    endtask : t_simd

    task automatic t_trap();
        for (int k = 0; k < 2; k++) begin
            prep(tsel(4 * k), tsel(4 * k + 1), tsel(4 * k + 2), tsel(4 * k + 3));
            trap <= 8'hff;
            @(posedge i_clk);
            trap <= 8'h80 >> (4 * k);
            fin("trap", 32'h2, 32'h1, 32'h1, 32'h1);
        end
        prep(perf_event_pkg::EV_TRAP_ALL, perf_event_pkg::EV_TRAP_SPILL,
             perf_event_pkg::EV_TRAP_DMMU, perf_event_pkg::EV_CYCLE);
        trap <= 8'hff;
        @(posedge i_clk);
        trap <= 8'h22;
        fin("trap_all", 32'ha, 32'h2, 32'h2, 32'h2);
    endtask : t_trap

    task automatic t_wait();
        prep(perf_event_pkg::EV_MEM_WAIT, perf_event_pkg::EV_MEM_WAIT_L2MISS,
             perf_event_pkg::EV_EXEC_WAIT, perf_event_pkg::EV_BRANCH_WAIT);
        oldest <= '{is_mem: 1'b1, l2_miss: 1'b1, default: 1'b0};
        @(posedge i_clk);
        oldest <= '{is_mem: 1'b1, is_store: 1'b1, l2_miss: 1'b1, default: 1'b0};
        @(posedge i_clk);
        oldest <= '{is_eu: 1'b1, is_branch: 1'b1, default: 1'b0};
        @(posedge i_clk);
        oldest <= '{is_branch: 1'b1, default: 1'b0};
        @(posedge i_clk);
        commit.slot[0].valid <= 1'b1;
        fin("wait", 32'h1, 32'h1, 32'h1, 32'h1);
        prep(perf_event_pkg::EV_MEM_WAIT_NC, perf_event_pkg::EV_MEM_WAIT_INT,
             perf_event_pkg::EV_MEM_WAIT_PFP, perf_event_pkg::EV_ISSUE2);
        oldest <= '{is_mem: 1'b1, noncache: 1'b1, integer_op: 1'b1, default: 1'b0};
        issue <= '{count: 3'h2, default: '0};
        @(posedge i_clk);
        oldest <= '{is_mem: 1'b1, pfp_busy: 1'b1, integer_op: 1'b1, default: 1'b0};
        fin("wait_sub", 32'h1, 32'h2, 32'h1, 32'h2);
    endtask : t_wait

    task automatic t_issue();
        prep(perf_event_pkg::EV_ISSUE0, perf_event_pkg::EV_ISSUE4,
             perf_event_pkg::EV_DECODE_INTLK, perf_event_pkg::EV_EXEC_HALT);
        issue <= '{count: 3'h4, sync_intlk: 1'b1, halt_order: 1'b1, default: '0};
        @(posedge i_clk);
        issue <= '{regwin_intlk: 1'b1, halt_retry: 1'b1, default: '0};
        @(posedge i_clk);
        issue <= '{other_static_intlk: 1'b1, halt_trap: 1'b1, halt_priv: 1'b1, default: '0};
        @(posedge i_clk);
        issue <= '{count: 3'h3, default: '0};
        fin("issue", 32'h2, 32'h1, 32'h3, 32'h3);
    endtask : t_issue

    // Last cycle also clears counter 3, so the clear must beat its increment
    task automatic t_priv();
        prep(perf_event_pkg::EV_CYCLE, perf_event_pkg::EV_CYCLE,
             perf_event_pkg::EV_FLUSH, perf_event_pkg::EV_ISSUE_EMPTY);
        ctrl[0].system_trace_enable <= 1'b0;
        ctrl[1].user_trace_enable <= 1'b0;
        issue <= '{iwr_empty: 1'b1, default: '0};
        @(posedge i_clk);
        issue <= '{iwr_empty: 1'b1, mispredict_flush_event: 1'b1, default: '0};
        @(posedge i_clk);
        sys_mode <= 1'b1;
        issue <= '{iwr_empty: 1'b1, default: '0};
        @(posedge i_clk);
        clr <= 4'h8;
        fin("priv", 32'h2, 32'h2, 32'h1, 32'h0);
    endtask : t_priv

    task automatic report_and_stop();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        fin("reset", 32'h0, 32'h0, 32'h0, 32'h0);
        t_commit();
        t_class();
        t_simd();
        t_trap();
        t_wait();
        t_issue();
        t_priv();
        report_and_stop();
    end
endmodule : perf_event_instr_trap_stats_tb
`default_nettype wire
